// File: hs_counter_status_compare_tb.sv
// Self-checking bench for the counter/compare block
`timescale 1ns/1ps
`define CHK(got, exp) \
  checks_done++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("unexpected at %0t: value mismatch", $time); \
  end
module hs_counter_status_compare_tb;
  logic                clk;
  logic                rst;
  hsc_pkg::hsc_mode_t  mode;
  logic                wdt, stf, tba, step, dir;
  logic [3:0]          ch1_in, ch2_hi, psel, pin, oclr;
  logic [1:0]          ab;
  hsc_pkg::hsc_cfg_t   cfg1, cfg2;
  logic [31:0]         cnt1, cnt2, rate1, rate2, rscale;
  logic [3:0]          outs;
  hsc_pkg::hsc_lamps_t lamps;
  int                  errors, checks_done;

  hsc_enc_model enc_u (.clk(clk), .rst(rst), .step(step), .dir(dir), .ab(ab));

  hsc_top dut_u (
    .CLK(clk), .RESET(rst), .MODE(mode), .WDT_TIMEOUT(wdt),
    .SELFTEST_FAIL(stf), .TB_ABSENT(tba), .CH1_IN(ch1_in),
    .CH2_IN({ch2_hi[3:2], ab}), .CH1_CFG(cfg1), .CH2_CFG(cfg2),
    .OUT_PULSE_SEL(psel), .OUT_PULSE_IN(pin), .OUT_CLEAR(oclr),
    .RATE_SCALE(rscale), .CH1_COUNT(cnt1), .CH2_COUNT(cnt2),
    .CH1_RATE(rate1), .CH2_RATE(rate2), .OUT_PTS(outs), .LAMPS(lamps)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // One rising edge on point A, two cycles high and two low
  task automatic pulse_a;
    ch1_in[0] = 1'b1;
    tick(2);
    ch1_in[0] = 1'b0;
    tick(2);
  endtask : pulse_a

  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #20000;
    errors++;
    report_and_stop();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    rst = 1'b1;
    mode = hsc_pkg::HSC_MODE_RUN;
    {wdt, stf, tba, step, dir} = '0;
    {ch1_in, ch2_hi, psel, pin, oclr} = '0;
    rscale = 32'h3E8;
    cfg1 = '{fn: hsc_pkg::HSC_FN_UPCNT, signed_mode: 1'b0, rst_en: 1'b1,
             inh_en: 1'b1, setpoint: 32'h3, out_map: 4'h1};
    cfg2 = '{fn: hsc_pkg::HSC_FN_QUAD, signed_mode: 1'b1, rst_en: 1'b0,
             inh_en: 1'b0, setpoint: 32'hFFFF, out_map: 4'h0};
    tick(3);
    `CHK(outs, 4'h0)
    rst = 1'b0;
    tick(3);
    `CHK(lamps.health, 1'b1)
    `CHK(lamps.fault, 1'b0)
    repeat (3) pulse_a();
    `CHK(outs[0], 1'b1)
    `CHK(cnt1, 32'h3)
    tick(1);
    `CHK(lamps.out[0], 1'b1)
    ch1_in[2] = 1'b1;
    tick(3);
    `CHK(cnt1, 32'h0)
    ch1_in[2] = 1'b0;
    oclr = 4'h1;
    tick(1);
    oclr = 4'h0;
    tick(2);
    `CHK(outs[0], 1'b0)
    ch1_in[3] = 1'b1;
    repeat (2) pulse_a();
    `CHK(cnt1, 32'h0)
    ch1_in[3] = 1'b0;
    pulse_a();
    `CHK(cnt1, 32'h1)
    ch1_in = 4'hA;
    tick(3);
    `CHK(lamps.ch1_in, 4'hA)
    ch1_in = 4'h0;
    step = 1'b1;
    dir = 1'b1;
    tick(4);
    step = 1'b0;
    tick(3);
    `CHK(cnt2 == 32'h4 || cnt2 == 32'hFFFFFFFC, 1'b1)
    `CHK(lamps.ch2_in[1:0], ab)
    `CHK(cnt1, 32'h1)
    dir = 1'b0;
    step = 1'b1;
    tick(4);
    step = 1'b0;
    tick(3);
    `CHK(cnt2, 32'h0)
    `CHK(rate2, 32'h0)
    // Rising A edges 2501 cycles apart span exactly ten microsecond ticks
    cfg1.fn = hsc_pkg::HSC_FN_TIMER;
    pulse_a();
    `CHK(rate1, 32'h3E8)
    tick(2497);
    pulse_a();
    `CHK(rate1, 32'h64)
    psel = 4'h2;
    pin = 4'h2;
    tick(3);
    `CHK(outs, 4'h2)
    pin = 4'h0;
    tick(3);
    `CHK(outs, 4'h0)
    mode = hsc_pkg::HSC_MODE_PROG;
    tick(3);
    `CHK(lamps.health, 1'b0)
    mode = hsc_pkg::HSC_MODE_BOOT;
    tick(3);
    `CHK(lamps.health, 1'b0)
    mode = hsc_pkg::HSC_MODE_RUN;
    tba = 1'b1;
    tick(3);
    `CHK(lamps.tb_missing, 1'b1)
    stf = 1'b1;
    tick(3);
    `CHK(lamps.health, 1'b0)
    `CHK(lamps.fault, 1'b0)
    wdt = 1'b1;
    tick(3);
    `CHK(lamps.fault, 1'b1)
    `CHK(lamps.health, 1'b0)
    report_and_stop();
  end
endmodule : hs_counter_status_compare_tb

// File: hsc_enc_model.sv
// Quadrature encoder model driving the A and B points of one channel
`timescale 1ns/1ps
module hsc_enc_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       step,
  input  wire logic       dir,
  output logic [1:0]      ab
);
  logic [1:0] phase_q;

  // One Gray step per clock at most
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= 2'h0;
    end else if (step) begin
      phase_q <= dir ? phase_q + 2'h1 : phase_q - 2'h1;
    end
  end

  assign ab = {phase_q[1], phase_q[1] ^ phase_q[0]};
endmodule : hsc_enc_model

// File: hsc_pkg.sv
// Package: constants and carrier types for the counter/compare block
package hsc_pkg;
  localparam int CLK_MHZ      = 250;
  localparam int US_NS        = 1000;
  localparam int CLK_NS       = 4;
  localparam int US_CYC       = US_NS / CLK_NS;
  localparam int BLINK_MS     = 250;
  localparam int BLINK_CYC    = BLINK_MS * 1000 * CLK_MHZ;
  localparam int NCH          = 2;
  localparam int NPT          = 4;
  localparam int NOUT         = 4;
  localparam logic [1:0] PT_A = 2'h0;
  localparam logic [1:0] PT_B = 2'h1;
  localparam logic [1:0] PT_C = 2'h2;
  localparam logic [1:0] PT_D = 2'h3;

  typedef enum logic [1:0] {
    HSC_MODE_RUN,
    HSC_MODE_PROG,
    HSC_MODE_BOOT
  } hsc_mode_t;

  typedef enum logic [1:0] {
    HSC_FN_OFF,
    HSC_FN_QUAD,
    HSC_FN_UPCNT,
    HSC_FN_TIMER
  } hsc_fn_t;

  // Per-channel configuration
  typedef struct packed {
    hsc_fn_t     fn;
    logic        signed_mode;
    logic        rst_en;
    logic        inh_en;
    logic [31:0] setpoint;
    logic [3:0]  out_map;
  } hsc_cfg_t;

  // Status indicator set
  typedef struct packed {
    logic       health;
    logic       fault;
    logic [3:0] ch1_in;
    logic [3:0] ch2_in;
    logic [1:0] ch1_fn;
    logic [1:0] ch2_fn;
    logic [3:0] out;
    logic       tb_missing;
  } hsc_lamps_t;
endpackage : hsc_pkg

// File: hsc_top.sv
// Two-channel counter/timer with setpoint compare and status lamps
`timescale 1ns/1ps
module hsc_top (
  input  wire logic                CLK,
  input  wire logic                RESET,
  input  wire hsc_pkg::hsc_mode_t  MODE,
  input  wire logic                WDT_TIMEOUT,
  input  wire logic                SELFTEST_FAIL,
  input  wire logic                TB_ABSENT,
  input  wire logic [3:0]          CH1_IN,
  input  wire logic [3:0]          CH2_IN,
  input  wire hsc_pkg::hsc_cfg_t   CH1_CFG,
  input  wire hsc_pkg::hsc_cfg_t   CH2_CFG,
  input  wire logic [3:0]          OUT_PULSE_SEL,
  input  wire logic [3:0]          OUT_PULSE_IN,
  input  wire logic [3:0]          OUT_CLEAR,
  input  wire logic [31:0]         RATE_SCALE,
  output logic [31:0]              CH1_COUNT,
  output logic [31:0]              CH2_COUNT,
  output logic [31:0]              CH1_RATE,
  output logic [31:0]              CH2_RATE,
  output logic [3:0]               OUT_PTS,
  output hsc_pkg::hsc_lamps_t      LAMPS
);
  localparam int BW = $clog2(hsc_pkg::BLINK_CYC);
  localparam int UW = $clog2(hsc_pkg::US_CYC);
  localparam logic [BW-1:0] BLINK_LAST = BW'(hsc_pkg::BLINK_CYC - 1);
  localparam logic [UW-1:0] US_LAST    = UW'(hsc_pkg::US_CYC - 1);

  logic [BW-1:0] blink_cnt_q;
  logic          blink_q;
  logic [UW-1:0] us_cnt_q;
  logic          us_tick_q;
  logic [3:0]    in_q [hsc_pkg::NCH];
  logic [3:0]    in_prev_q [hsc_pkg::NCH];
  logic [31:0]   cnt_q [hsc_pkg::NCH];
  logic [31:0]   tmr_q [hsc_pkg::NCH];
  logic [31:0]   rate_q [hsc_pkg::NCH];
  logic [1:0]    act_q [hsc_pkg::NCH];
  logic [3:0]    hit_q;
  logic [3:0]    disc_q;
  logic [3:0]    out_q;
  hsc_pkg::hsc_cfg_t cfg [hsc_pkg::NCH];

  assign cfg[0] = CH1_CFG;
  assign cfg[1] = CH2_CFG;

  // Quadrature step: +1, -1 or 0 from A/B transition
  function automatic logic [1:0] quad_step(input logic [1:0] pv,
                                           input logic [1:0] nw);
    logic [3:0] k;
    k = {pv, nw};
    case (k)
      4'h1, 4'h7, 4'hE, 4'h8: quad_step = 2'h1;
      4'h2, 4'hB, 4'hD, 4'h4: quad_step = 2'h3;
      default:                quad_step = 2'h0;
    endcase
  endfunction : quad_step

  // Shared blink source
  always_ff @(posedge CLK) begin
    if (RESET) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q == BLINK_LAST) begin
      blink_cnt_q <= '0;
      blink_q     <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 1'b1;
    end
  end

  // Microsecond tick
  always_ff @(posedge CLK) begin
    if (RESET) begin
      us_cnt_q  <= '0;
      us_tick_q <= 1'b0;
    end else begin
      us_tick_q <= (us_cnt_q == US_LAST);
      us_cnt_q  <= (us_cnt_q == US_LAST) ? '0 : us_cnt_q + 1'b1;
    end
  end

  // Per-channel counting and timing
  for (genvar c = 0; c < hsc_pkg::NCH; c++) begin : g_ch
    logic [1:0] step;
    logic       inh;
    logic       rst;
    logic       edge_a;
    assign step   = quad_step({in_prev_q[c][hsc_pkg::PT_A],
                               in_prev_q[c][hsc_pkg::PT_B]},
                              {in_q[c][hsc_pkg::PT_A],
                               in_q[c][hsc_pkg::PT_B]});
    assign inh    = cfg[c].inh_en & in_q[c][hsc_pkg::PT_D];
    assign rst    = cfg[c].rst_en & in_q[c][hsc_pkg::PT_C];
    assign edge_a = in_q[c][hsc_pkg::PT_A] & ~in_prev_q[c][hsc_pkg::PT_A];

    always_ff @(posedge CLK) begin
      if (RESET) begin
        in_q[c]      <= '0;
        in_prev_q[c] <= '0;
      end else begin
        in_q[c]      <= (c == 0) ? CH1_IN : CH2_IN;
        in_prev_q[c] <= in_q[c];
      end
    end

    always_ff @(posedge CLK) begin
      if (RESET) begin
        cnt_q[c] <= '0;
        act_q[c] <= '0;
      end else if (rst) begin
        cnt_q[c] <= '0;
        act_q[c] <= '0;
      end else if (inh) begin
        act_q[c] <= '0;
      end else begin
        case (cfg[c].fn)
          hsc_pkg::HSC_FN_QUAD: begin
            cnt_q[c] <= cnt_q[c] + {{30{step[1]}}, step};
            act_q[c][0] <= (step != 2'h0);
          end
          hsc_pkg::HSC_FN_UPCNT: begin
            if (edge_a) begin
              cnt_q[c] <= cnt_q[c] + 32'h1;
            end
            act_q[c][0] <= edge_a;
          end
          default: act_q[c][0] <= 1'b0;
        endcase
        act_q[c][1] <= (cfg[c].fn == hsc_pkg::HSC_FN_TIMER);
      end
    end

    // Edge timer and scaled rate
    always_ff @(posedge CLK) begin
      if (RESET) begin
        tmr_q[c]  <= '0;
        rate_q[c] <= '0;
      end else if (cfg[c].fn != hsc_pkg::HSC_FN_TIMER) begin
        tmr_q[c] <= '0;
      end else if (edge_a) begin
        rate_q[c] <= (tmr_q[c] == 32'h0) ? RATE_SCALE
                     : RATE_SCALE / tmr_q[c];
        tmr_q[c]  <= '0;
      end else if (us_tick_q && tmr_q[c] != 32'hFFFFFFFF) begin
        tmr_q[c] <= tmr_q[c] + 32'h1;
      end
    end
  end

  // Setpoint compare, signed or unsigned equality
  always_ff @(posedge CLK) begin
    if (RESET) begin
      hit_q <= '0;
    end else begin
      hit_q <= ((cnt_q[0] == CH1_CFG.setpoint &&
                 CH1_CFG.fn != hsc_pkg::HSC_FN_OFF) ? CH1_CFG.out_map : 4'h0)
             | ((cnt_q[1] == CH2_CFG.setpoint &&
                 CH2_CFG.fn != hsc_pkg::HSC_FN_OFF) ? CH2_CFG.out_map
                                                    : 4'h0);
    end
  end

  // Discrete outputs latch on a hit, clear on request
  always_ff @(posedge CLK) begin
    if (RESET) begin
      disc_q <= '0;
    end else begin
      disc_q <= (disc_q & ~OUT_CLEAR) | hit_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      out_q <= '0;
    end else begin
      out_q <= (OUT_PULSE_SEL & OUT_PULSE_IN)
             | (~OUT_PULSE_SEL & ((disc_q & ~OUT_CLEAR) | hit_q));
    end
  end

  assign OUT_PTS   = out_q;
  assign CH1_COUNT = cnt_q[0];
  assign CH2_COUNT = cnt_q[1];
  assign CH1_RATE  = rate_q[0];
  assign CH2_RATE  = rate_q[1];

  // Lamp drive
  always_ff @(posedge CLK) begin
    if (RESET) begin
      LAMPS <= '0;
    end else begin
      if (WDT_TIMEOUT) begin
        LAMPS.health <= 1'b0;
        LAMPS.fault  <= 1'b1;
      end else if (SELFTEST_FAIL) begin
        LAMPS.health <= 1'b0;
        LAMPS.fault  <= blink_q;
      end else begin
        case (MODE)
          hsc_pkg::HSC_MODE_RUN: begin
            LAMPS.health <= 1'b1;
            LAMPS.fault  <= 1'b0;
          end
          hsc_pkg::HSC_MODE_BOOT: begin
            LAMPS.health <= blink_q;
            LAMPS.fault  <= blink_q;
          end
          default: begin
            LAMPS.health <= blink_q;
            LAMPS.fault  <= 1'b0;
          end
        endcase
      end
      LAMPS.ch1_in     <= in_q[0];
      LAMPS.ch2_in     <= in_q[1];
      LAMPS.ch1_fn     <= {act_q[0][1] & blink_q,
                           act_q[0][0] & blink_q};
      LAMPS.ch2_fn     <= {act_q[1][1] & blink_q,
                           act_q[1][0] & blink_q};
      LAMPS.out        <= out_q;
      LAMPS.tb_missing <= TB_ABSENT;
    end
  end

  // Rule checks
  a_out_hit: assert property (@(posedge CLK) disable iff (RESET)
    (hit_q != 4'h0) |=> ((out_q & ~$past(OUT_PULSE_SEL) & $past(hit_q))
                         == (~$past(OUT_PULSE_SEL) & $past(hit_q))))
    else $error("Hit did not drive output");
  a_inh_hold: assert property (@(posedge CLK) disable iff (RESET)
    (CH1_CFG.inh_en && in_q[0][hsc_pkg::PT_D] &&
     !(CH1_CFG.rst_en && in_q[0][hsc_pkg::PT_C])) |=> $stable(cnt_q[0]))
    else $error("Count moved while inhibited");
  a_rst_zero: assert property (@(posedge CLK) disable iff (RESET)
    (CH1_CFG.rst_en && in_q[0][hsc_pkg::PT_C]) |=> (cnt_q[0] == 32'h0))
    else $error("Reset input did not clear count");
  a_wdt_lamps: assert property (@(posedge CLK) disable iff (RESET)
    WDT_TIMEOUT |=> (!LAMPS.health && LAMPS.fault))
    else $error("Watchdog lamp pattern wrong");
  a_run_lamps: assert property (@(posedge CLK) disable iff (RESET)
    (!WDT_TIMEOUT && !SELFTEST_FAIL && MODE == hsc_pkg::HSC_MODE_RUN)
      |=> (LAMPS.health && !LAMPS.fault))
    else $error("Run lamp pattern wrong");
  a_in_mirror: assert property (@(posedge CLK) disable iff (RESET)
    ##1 1'b1 |-> ##1 (LAMPS.ch1_in == $past(in_q[0])))
    else $error("Input lamp mismatch");
  a_out_lamp: assert property (@(posedge CLK) disable iff (RESET)
    ##1 1'b1 |-> (LAMPS.out == $past(out_q)))
    else $error("Output lamp mismatch");
  a_tb_flag: assert property (@(posedge CLK) disable iff (RESET)
    TB_ABSENT |=> LAMPS.tb_missing)
    else $error("Terminal block flag missing");
  a_us_tick: assert property (@(posedge CLK) disable iff (RESET)
    us_tick_q |=> (!us_tick_q) [*8])
    else $error("Microsecond tick too frequent");
  a_fn_idle: assert property (@(posedge CLK) disable iff (RESET)
    (act_q[0] == 2'h0) |=> (LAMPS.ch1_fn == 2'h0))
    else $error("Activity lamp lit while idle");
  a_hit_cmp: assert property (@(posedge CLK) disable iff (RESET)
    (CH1_CFG.fn != hsc_pkg::HSC_FN_OFF && cnt_q[0] == CH1_CFG.setpoint)
      |=> ((hit_q & $past(CH1_CFG.out_map)) == $past(CH1_CFG.out_map)))
    else $error("Setpoint match not flagged");
  a_hit_wins: assert property (@(posedge CLK) disable iff (RESET)
    (hit_q != 4'h0) |=> ((disc_q & $past(hit_q)) == $past(hit_q)))
    else $error("Clear beat a setpoint hit");
  a_tmr_idle: assert property (@(posedge CLK) disable iff (RESET)
    (CH1_CFG.fn != hsc_pkg::HSC_FN_TIMER) |=> (tmr_q[0] == 32'h0))
    else $error("Timer ran outside timing mode");
  a_prog_lamps: assert property (@(posedge CLK) disable iff (RESET)
    (!WDT_TIMEOUT && !SELFTEST_FAIL && MODE == hsc_pkg::HSC_MODE_PROG)
      |=> (!LAMPS.fault))
    else $error("Program lamp pattern wrong");
  a_boot_lamps: assert property (@(posedge CLK) disable iff (RESET)
    (!WDT_TIMEOUT && !SELFTEST_FAIL && MODE == hsc_pkg::HSC_MODE_BOOT)
      |=> (LAMPS.health == LAMPS.fault))
    else $error("Boot lamp pattern wrong");

  // Scenario covers
  c_hit:  cover property (@(posedge CLK) hit_q != 4'h0);
  c_inh:  cover property (@(posedge CLK) CH1_CFG.inh_en && in_q[0][3]);
  c_quad: cover property (@(posedge CLK) act_q[0][0]);
  c_rate: cover property (@(posedge CLK) CH1_RATE != 32'h0);
  c_timer: cover property (@(posedge CLK) act_q[0][1]);
endmodule : hsc_top
